// *** hw/msi_pkg.sv ***
// constants, register map and state layout of the module status indication block
package msi_pkg;
   // register byte offsets
   localparam logic [7:0] MSI_CTRL_OFS     = 8'h00;
   localparam logic [7:0] MSI_BAND_OFS     = 8'h04;
   localparam logic [7:0] MSI_PATTERN_OFS  = 8'h08;
   localparam logic [7:0] MSI_PINFUNC_OFS  = 8'h0C;
   localparam logic [7:0] MSI_STATUS_OFS   = 8'h10;
   localparam logic [7:0] MSI_IRQSTAT_OFS  = 8'h14;
   localparam logic [7:0] MSI_IRQMASK_OFS  = 8'h18;
   // control register fields
   localparam int CTRL_BANDSEL_BIT = 0;
   localparam int CTRL_LED_BIT     = 1;
   localparam int CTRL_WAKEIRQ_BIT = 2;
   localparam int CTRL_WAKE_BIT    = 3;
   localparam int CTRL_RING_BIT    = 4;
   // pattern register fields
   localparam int PAT_BAND_LSB     = 8;
   // pin function register fields
   localparam int PF_DIR_LSB       = 4;
   localparam int PF_VAL_LSB       = 8;
   // status register fields
   localparam int ST_CARD_BIT      = 0;
   localparam int ST_RADIO_BIT     = 1;
   localparam int ST_TX_BIT        = 2;
   // interrupt event bits
   localparam int IRQ_INSERT_BIT   = 0;
   localparam int IRQ_REMOVE_BIT   = 1;
   localparam int IRQ_RADIO_BIT    = 2;
   localparam int IRQ_RING_BIT     = 3;
   localparam int IRQ_W            = 4;
   // reset values
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
   localparam logic [3:0]       BAND_RST     = 4'h0;
   // timing: pulse width of ring and second pulses
   localparam int CLK_PERIOD_NS  = 20;
   localparam int PULSE_TIME_NS  = 1000;
   localparam int PULSE_CYCLES   = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W          = 8;
   localparam int LINES          = 4;
   localparam int BANDS          = 16;

   typedef struct packed {
      logic                         band_select_enable;
      logic                         ledOn;
      logic                         wakeOnIrq;
      logic                         hostWake;
      logic [3:0]                   bandIdx;
      logic [BANDS-1:0][LINES-1:0]  bandPat;
      logic [LINES-1:0]             gpioSel;
      logic [LINES-1:0]             gpioDir;
      logic [LINES-1:0]             gpioVal;
      logic [LINES-1:0]             antIn1;
      logic [LINES-1:0]             antIn2;
      logic                         card1;
      logic                         card2;
      logic                         cardPrev;
      logic                         dis1;
      logic                         dis2;
      logic                         disPrev;
      logic [IRQ_W-1:0]             irqStat;
      logic [IRQ_W-1:0]             irqMask;
      logic [CNT_W-1:0]             ringCnt;
      logic [CNT_W-1:0]             syncCnt;
      logic [LINES-1:0]             antOut;
      logic [LINES-1:0]             antOe;
      logic                         txOut;
      logic                         safeOut;
      logic [31:0]                  rdData;
      logic                         rdErr;
   } msi_state_s;
endpackage

// *** hw/msi_status_indications.sv ***
// status and indication pin logic with its apb register file
//
// Notes on behaviour
// - tuning lines zero to three follow the four-bit pattern of the selected band
// - band tuning only when band select enable is set; rst clears it
// - any tuning line can be switched to a general purpose pin
// - transmit flag high while the radio transmits, low otherwise
// - led line only sinks current, never driven high
// - host wake line driven high on a wake-worthy event
// - each notifiable event gives one high pulse on the ring line
// - supply removal flag high only when removal is safe
// - card detect is pulled up; high means card present
// - rising card detect is insertion, falling is removal
// - one pulse per satellite second, aligned while fixes are obtained
// - without a fix keep pulsing while time uncertainty is low
// - stop the second pulse once time uncertainty is high
// - radio neither sends nor receives while disable input is low
// - disable input is pulled up so a floating pin means radio on
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module msi_status_indications #(
   parameter int PULSE_LEN = msi_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic                          pready,
   output logic [31:0]                   prdata,
   output logic                          pslverr,
   output logic                          irq,
   // from the radio, power and satellite cores
   input  wire logic                     txBusy,
   input  wire logic                     supplySafe,
   input  wire logic                     ringEvent,
   input  wire logic                     wakeEvent,
   input  wire logic                     secondTick,
   input  wire logic                     fixValid,
   input  wire logic                     uncertHigh,
   output logic                          radioAllowed,
   // antenna tuning lines, two-way when used as general purpose pins
   input  wire logic [msi_pkg::LINES-1:0] antenna_tune_in,
   output logic [msi_pkg::LINES-1:0]      antenna_tune_out,
   output logic [msi_pkg::LINES-1:0]      antenna_tune_oe,
   // indication pins
   output logic                          tx_activity_out,
   output logic                          radio_led_sink,
   output logic                          radio_led_sink_oe,
   output logic                          host_wake_out,
   output logic                          ring_event_out,
   output logic                          supply_removal_ok,
   output logic                          satellite_second_pulse,
   input  wire logic                     card_present_in,
   input  wire logic                     radio_disable_n_in
);
   import msi_pkg::*;

   localparam logic [CNT_W-1:0] PULSE_LEN_C = CNT_W'(PULSE_LEN);

   msi_state_s cur_r;
   msi_state_s st_nxt;

   logic             setupRd;
   logic             accessWr;
   logic             accessRd;
   logic             mapped;
   logic [IRQ_W-1:0] events;
   logic             ringFire;
   logic             syncFire;
   logic [3:0]       patBand;
   logic [LINES-1:0] selPat;

   // one register decoder for write, read capture and error answer
   function automatic logic regMapped(input logic [7:0] addr);
      case (addr)
         MSI_CTRL_OFS, MSI_BAND_OFS, MSI_PATTERN_OFS, MSI_PINFUNC_OFS,
         MSI_STATUS_OFS, MSI_IRQSTAT_OFS, MSI_IRQMASK_OFS: regMapped = 1'b1;
         default:                                          regMapped = 1'b0;
      endcase
   endfunction

   assign mapped = regMapped(paddr);

   // pattern of the selected band, shared by the line drive, the read and the check
   assign selPat = cur_r.bandPat[cur_r.bandIdx];

   // read data is captured in the setup cycle so prdata comes from a flop
   assign setupRd  = psel && !penable && !pwrite;
   assign accessWr = psel && penable && pwrite && mapped;
   assign accessRd = psel && penable && !pwrite;
   assign patBand  = pwdata[PAT_BAND_LSB +: 4];
   assign ringFire = ringEvent || (accessWr && paddr == MSI_CTRL_OFS && pwdata[CTRL_RING_BIT]);

   // second pulse passes while fixing or while uncertainty is low
   assign syncFire = secondTick && (fixValid || !uncertHigh);

   // edges of the synchronised card detect and disable levels, and the ring event
   always_comb begin
      events = '0;
      events[IRQ_INSERT_BIT] = cur_r.card2 && !cur_r.cardPrev;
      events[IRQ_REMOVE_BIT] = !cur_r.card2 && cur_r.cardPrev;
      events[IRQ_RADIO_BIT]  = cur_r.dis2 != cur_r.disPrev;
      events[IRQ_RING_BIT]   = ringFire;
   end

   // next state of the whole block
   always_comb begin
      st_nxt = cur_r;
      // two-stage synchronisers; stage one feeds only stage two
      st_nxt.card1    = card_present_in;
      st_nxt.card2    = cur_r.card1;
      st_nxt.cardPrev = cur_r.card2;
      st_nxt.dis1     = radio_disable_n_in;
      st_nxt.dis2     = cur_r.dis1;
      st_nxt.disPrev  = cur_r.dis2;
      st_nxt.antIn1   = antenna_tune_in;
      st_nxt.antIn2   = cur_r.antIn1;

      // register writes
      if (accessWr) begin
         unique case (paddr)
            MSI_CTRL_OFS: begin
               // band select enable is held until software clears it
               st_nxt.band_select_enable = pwdata[CTRL_BANDSEL_BIT];
               st_nxt.ledOn     = pwdata[CTRL_LED_BIT];
               st_nxt.wakeOnIrq = pwdata[CTRL_WAKEIRQ_BIT];
               st_nxt.hostWake  = pwdata[CTRL_WAKE_BIT];
            end
            MSI_BAND_OFS:    st_nxt.bandIdx = pwdata[3:0];
            MSI_PATTERN_OFS: st_nxt.bandPat[patBand] = pwdata[LINES-1:0];
            MSI_PINFUNC_OFS: begin
               st_nxt.gpioSel = pwdata[LINES-1:0];
               st_nxt.gpioDir = pwdata[PF_DIR_LSB +: LINES];
               st_nxt.gpioVal = pwdata[PF_VAL_LSB +: LINES];
            end
            MSI_IRQMASK_OFS: st_nxt.irqMask = pwdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      // a wake event raises the wake level until software drops it
      if (wakeEvent) begin
         st_nxt.hostWake = 1'b1;
      end

      // read capture and error flag in the setup cycle
      if (setupRd) begin
         st_nxt.rdData = '0;
         unique case (paddr)
            MSI_CTRL_OFS: begin
               st_nxt.rdData[CTRL_BANDSEL_BIT] = cur_r.band_select_enable;
               st_nxt.rdData[CTRL_LED_BIT]     = cur_r.ledOn;
               st_nxt.rdData[CTRL_WAKEIRQ_BIT] = cur_r.wakeOnIrq;
               st_nxt.rdData[CTRL_WAKE_BIT]    = cur_r.hostWake;
            end
            MSI_BAND_OFS:    st_nxt.rdData[3:0] = cur_r.bandIdx;
            MSI_PATTERN_OFS: st_nxt.rdData[LINES-1:0] = selPat;
            MSI_PINFUNC_OFS: begin
               st_nxt.rdData[LINES-1:0]           = cur_r.gpioSel;
               st_nxt.rdData[PF_DIR_LSB +: LINES] = cur_r.gpioDir;
               st_nxt.rdData[PF_VAL_LSB +: LINES] = cur_r.antIn2;
            end
            MSI_STATUS_OFS: begin
               // high on the card detect means a card is present
               st_nxt.rdData[ST_CARD_BIT]  = cur_r.card2;
               st_nxt.rdData[ST_RADIO_BIT] = cur_r.dis2;
               st_nxt.rdData[ST_TX_BIT]    = cur_r.txOut;
            end
            MSI_IRQSTAT_OFS: st_nxt.rdData[IRQ_W-1:0] = cur_r.irqStat;
            MSI_IRQMASK_OFS: st_nxt.rdData[IRQ_W-1:0] = cur_r.irqMask;
            default: begin
            end
         endcase
         st_nxt.rdErr = !mapped;
      end

      // sticky events; only bits that were read are cleared, a new event wins
      if (accessRd && paddr == MSI_IRQSTAT_OFS) begin
         st_nxt.irqStat = (cur_r.irqStat & ~cur_r.rdData[IRQ_W-1:0]) | events;
      end else begin
         st_nxt.irqStat = cur_r.irqStat | events;
      end

      // ring pulse of fixed width per event; a new event restarts it
      if (ringFire) begin
         st_nxt.ringCnt = PULSE_LEN_C;
      end else if (cur_r.ringCnt != '0) begin
         st_nxt.ringCnt = cur_r.ringCnt - CNT_W'(1);
      end
      // one pulse on each accepted second tick
      // no tick passes once uncertainty is high and no fix exists
      if (syncFire) begin
         st_nxt.syncCnt = PULSE_LEN_C;
      end else if (cur_r.syncCnt != '0) begin
         st_nxt.syncCnt = cur_r.syncCnt - CNT_W'(1);
      end

      // band pattern drives the lines, line n from pattern bit n
      // with band select off the tuning lines are held low
      // lines marked as general purpose follow their own value and direction
      for (int i = 0; i < LINES; i++) begin
         if (cur_r.gpioSel[i]) begin
            st_nxt.antOut[i] = cur_r.gpioVal[i];
            st_nxt.antOe[i]  = cur_r.gpioDir[i];
         end else begin
            st_nxt.antOut[i] = cur_r.band_select_enable && selPat[i];
            st_nxt.antOe[i]  = 1'b1;
         end
      end

      // no transmission reported or allowed while disabled
      st_nxt.txOut   = txBusy && cur_r.dis2;
      // removal flag only when the power core says it is safe
      st_nxt.safeOut = supplySafe;
   end

   // the one state register; rst clears the band patterns and sets the card detect and disable synchroniser levels high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_r         <= '0;
         cur_r.card1   <= 1'b1;
         cur_r.card2   <= 1'b1;
         cur_r.cardPrev <= 1'b1;
         cur_r.dis1    <= 1'b1;
         cur_r.dis2    <= 1'b1;
         cur_r.disPrev <= 1'b1;
         cur_r.bandIdx <= BAND_RST;
         cur_r.irqMask <= IRQ_MASK_RST;
         cur_r.antOe   <= '1;
      end else begin
         cur_r <= st_nxt;
      end
   end

   // outputs
   assign pready   = psel && penable;
   assign prdata   = cur_r.rdData;
   assign pslverr  = psel && penable && cur_r.rdErr && !pwrite ? 1'b1 : (psel && penable && pwrite && !mapped);
   assign irq      = |(cur_r.irqStat & cur_r.irqMask);
   // a floating disable pin reads high through the pad pull-up, radio on
   assign radioAllowed          = cur_r.dis2;
   assign antenna_tune_out      = cur_r.antOut;
   assign antenna_tune_oe       = cur_r.antOe;
   assign tx_activity_out       = cur_r.txOut;
   // open drain: the line is only ever pulled low
   assign radio_led_sink        = 1'b0;
   assign radio_led_sink_oe     = cur_r.ledOn;
   // wake follows the level or, when chosen, the interrupt
   assign host_wake_out         = cur_r.hostWake || (cur_r.wakeOnIrq && irq);
   assign ring_event_out        = cur_r.ringCnt != '0;
   assign supply_removal_ok     = cur_r.safeOut;
   assign satellite_second_pulse = cur_r.syncCnt != '0;

   a_led_no_high: assert property (@(posedge clk) disable iff (rst) !radio_led_sink)
      else $error("led line driven high");

   // ring pulse stays high for at least two cycles once it rises
   a_ring_pulse_width: assert property (@(posedge clk) disable iff (rst)
      $rose(ring_event_out) |-> ring_event_out [*2] )
      else $error("ring pulse too short");

   // no second pulse starts while uncertain without fix
   a_sync_stop_uncertain: assert property (@(posedge clk) disable iff (rst)
      (secondTick && uncertHigh && !fixValid && !satellite_second_pulse) |=> !satellite_second_pulse)
      else $error("second pulse while uncertain");

   // tick with a valid fix gives a pulse next cycle
   a_sync_on_tick: assert property (@(posedge clk) disable iff (rst)
      (secondTick && fixValid) |=> satellite_second_pulse)
      else $error("second pulse missing");

   // transmit flag low within three cycles of a held disable
   a_tx_gated_disable: assert property (@(posedge clk) disable iff (rst)
      (!radio_disable_n_in) [*3] |=> !tx_activity_out)
      else $error("transmit while disabled");

   // card insertion sets its flag within four cycles
   a_card_insert_flag: assert property (@(posedge clk) disable iff (rst)
      $rose(card_present_in) ##1 card_present_in [*3] |=> cur_r.irqStat[IRQ_INSERT_BIT])
      else $error("card insertion not flagged");

   // tuning lines stay low while band select is off
   a_band_off_low: assert property (@(posedge clk) disable iff (rst)
      (!cur_r.band_select_enable && !$past(cur_r.band_select_enable) && cur_r.gpioSel == '0 && $past(cur_r.gpioSel) == '0)
      |-> antenna_tune_out == '0)
      else $error("tuning line active without band select");

   // enabled lines match the selected pattern one cycle later
   a_band_pattern_out: assert property (@(posedge clk) disable iff (rst)
      (cur_r.band_select_enable && cur_r.gpioSel == '0) |=> antenna_tune_out == $past(selPat))
      else $error("tuning lines differ from pattern");

   // removal flag tracks the power core by one cycle
   a_safe_follow: assert property (@(posedge clk) disable iff (rst)
      supply_removal_ok == $past(supplySafe))
      else $error("removal flag wrong");

   // transmit flag is the busy level gated by the synced disable, one cycle late
   a_tx_follow: assert property (@(posedge clk) disable iff (rst)
      tx_activity_out == ($past(txBusy) && $past(radioAllowed)))
      else $error("transmit flag wrong");

   // synced disable level blocks the radio within three cycles
   a_radio_gated: assert property (@(posedge clk) disable iff (rst)
      (!radio_disable_n_in) [*3] |=> !radioAllowed)
      else $error("radio still allowed while disabled");

   // card removal sets its flag within four cycles
   a_card_remove_flag: assert property (@(posedge clk) disable iff (rst)
      $fell(card_present_in) ##1 !card_present_in [*3] |=> cur_r.irqStat[IRQ_REMOVE_BIT])
      else $error("card removal not flagged");

   // an event sets its sticky bit even when a clearing read lands on it
   a_event_set_wins: assert property (@(posedge clk) disable iff (rst)
      (|events) |=> ((cur_r.irqStat & $past(events)) == $past(events)))
      else $error("event lost against read clear");

   // a wake event raises the host wake line on the next cycle
   a_wake_on_event: assert property (@(posedge clk) disable iff (rst)
      wakeEvent |=> host_wake_out)
      else $error("host wake missing");

   // a general purpose line drives only when its direction bit asks for it
   a_gpio_dir_follow: assert property (@(posedge clk) disable iff (rst)
      ((antenna_tune_oe ^ $past(cur_r.gpioDir)) & $past(cur_r.gpioSel)) == '0)
      else $error("general purpose direction wrong");

   // second pulse lasts at least two cycles, like the ring pulse
   a_sync_width: assert property (@(posedge clk) disable iff (rst)
      $rose(satellite_second_pulse) |-> satellite_second_pulse [*2])
      else $error("second pulse too short");

   // width counters never hold more than the configured length
   a_pulse_count_max: assert property (@(posedge clk) disable iff (rst)
      (cur_r.ringCnt <= PULSE_LEN_C) && (cur_r.syncCnt <= PULSE_LEN_C))
      else $error("pulse counter beyond width");

endmodule

// *** test/msi_host_board.sv ***
// host board model: pad pull-ups, socket switch, open-drain disable switch, led
`timescale 1ns/1ps
module msi_host_board (
   // host side controls
   input  wire logic hostPullDisable,
   input  wire logic cardInserted,
   // led pin from the module
   input  wire logic radio_led_sink,
   input  wire logic radio_led_sink_oe,
   // pins toward the module
   output logic      card_present_in,
   output logic      radio_disable_n_in,
   output logic      ledLit
);
   // pulled up, the empty socket grounds it
   assign card_present_in = cardInserted ? 1'b1 : 1'b0;
   // host only pulls low, otherwise the pull-up wins
   assign radio_disable_n_in = hostPullDisable ? 1'b0 : 1'b1;
   // lit only while the pin sinks; a driven high would short the supply
   assign ledLit = radio_led_sink_oe && (radio_led_sink === 1'b0);
endmodule

// *** test/msi_status_indications_tb.sv ***
// self-checking bench for the status indication block
`timescale 1ns/1ps
module msi_status_indications_tb;
   import msi_pkg::*;
   localparam int PL = 3;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        txBusy, supplySafe, ringEvent, wakeEvent, secondTick, fixValid, uncertHigh, radioAllowed;
   logic [3:0]  antOut, antOe, antIn, extLines;
   logic        txAct, ledSink, ledOe, hostWake, ringOut, supplyOk, secPulse, cardPin, disPin;
   logic        hostPullDisable, cardInserted, ledLit;
   logic [3:0]  pats [4] = '{4'h5, 4'hA, 4'h3, 4'hC};
   int          numErrors, samplesChecked, n;

   // wire level of the tuning pins from both drivers
   // the far-side antenna switch is taken to settle at once, inside its 10 us limit
   assign antIn = (antOe & antOut) | (~antOe & extLines);

   msi_status_indications #(.PULSE_LEN(PL)) u_msi_status_indications (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
      .txBusy(txBusy), .supplySafe(supplySafe), .ringEvent(ringEvent), .wakeEvent(wakeEvent),
      .secondTick(secondTick), .fixValid(fixValid), .uncertHigh(uncertHigh), .radioAllowed(radioAllowed),
      .antenna_tune_in(antIn), .antenna_tune_out(antOut), .antenna_tune_oe(antOe),
      .tx_activity_out(txAct), .radio_led_sink(ledSink), .radio_led_sink_oe(ledOe),
      .host_wake_out(hostWake), .ring_event_out(ringOut), .supply_removal_ok(supplyOk),
      .satellite_second_pulse(secPulse), .card_present_in(cardPin), .radio_disable_n_in(disPin));

   msi_host_board u_msi_host_board (
      .hostPullDisable(hostPullDisable), .cardInserted(cardInserted), .radio_led_sink(ledSink),
      .radio_led_sink_oe(ledOe), .card_present_in(cardPin), .radio_disable_n_in(disPin), .ledLit(ledLit));

   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // compare one value, counting every check
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits for pready, no fixed latency assumed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // a slave that never answers counts as a mismatch
      if (pready !== 1'b1) begin
         numErrors++;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // count high cycles of the ring or second pulse over a fixed window
   task automatic cnt(input int which);
      n = 0;
      repeat (12) begin
         @(negedge clk);
         n += (which == 0) ? (ringOut === 1'b1) : (secPulse === 1'b1);
      end
   endtask

   // one-cycle event strobe: 0 ring, 1 second tick, 2 wake
   task automatic pulse(input int which);
      @(posedge clk);
      ringEvent  <= (which == 0);
      secondTick <= (which == 1);
      wakeEvent  <= (which == 2);
      @(posedge clk);
      ringEvent  <= 1'b0;
      secondTick <= 1'b0;
      wakeEvent  <= 1'b0;
      cnt(which);
   endtask

   task automatic finishTest();
      $display("checks %0d errors %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // watchdog well beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      numErrors++;
      finishTest();
   end

   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {txBusy, supplySafe, ringEvent, wakeEvent, secondTick, fixValid, uncertHigh} = 7'h0;
      {hostPullDisable, cardInserted, extLines} = {1'b0, 1'b1, 4'h2};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdchk(MSI_CTRL_OFS, 32'h0);
      rdchk(MSI_IRQMASK_OFS, 32'h0);
      rdchk(MSI_STATUS_OFS, 32'h3);
      apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h1C, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, MSI_STATUS_OFS, 32'h0);
      rdchk(MSI_STATUS_OFS, 32'h3);
      $display("test reset done");
      for (int b = 0; b < 4; b++) apb(1'b1, MSI_PATTERN_OFS, {20'h0, 4'(b), 4'h0, pats[b]});
      apb(1'b1, MSI_BAND_OFS, 32'h2);
      repeat (3) @(negedge clk);
      chk({28'h0, antOut}, 32'h0);
      apb(1'b1, MSI_CTRL_OFS, 32'h1);
      for (int b = 0; b < 4; b++) begin
         apb(1'b1, MSI_BAND_OFS, 32'(b));
         repeat (3) @(negedge clk);
         chk({antOe, antOut}, {24'h0, 4'hF, pats[b]});
         rdchk(MSI_PATTERN_OFS, {28'h0, pats[b]});
      end
      $display("test band tuning done");
      apb(1'b1, MSI_PINFUNC_OFS, 32'h113);
      repeat (4) @(negedge clk);
      chk({antOe, antOut & antOe}, 32'hDD);
      apb(1'b0, MSI_PINFUNC_OFS, 32'h0);
      chk((rd >> 8) & 32'hF, 32'hF);
      $display("test gpio done");
      @(posedge clk);
      txBusy     <= 1'b1;
      supplySafe <= 1'b1;
      repeat (3) @(negedge clk);
      chk({txAct, supplyOk}, 32'h3);
      rdchk(MSI_STATUS_OFS, 32'h7);
      @(posedge clk);
      hostPullDisable <= 1'b1;
      repeat (5) @(negedge clk);
      chk({txAct, radioAllowed}, 32'h0);
      rdchk(MSI_STATUS_OFS, 32'h1);
      @(posedge clk);
      {txBusy, supplySafe, hostPullDisable} <= 3'h0;
      repeat (5) @(negedge clk);
      chk({txAct, supplyOk, radioAllowed}, 32'h1);
      rdchk(MSI_IRQSTAT_OFS, 32'h4);
      rdchk(MSI_IRQSTAT_OFS, 32'h0);
      $display("test radio and supply done");
      apb(1'b1, MSI_IRQMASK_OFS, 32'hF);
      @(posedge clk);
      cardInserted <= 1'b0;
      repeat (5) @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      rdchk(MSI_STATUS_OFS, 32'h2);
      rdchk(MSI_IRQSTAT_OFS, 32'h2);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      cardInserted <= 1'b1;
      repeat (5) @(negedge clk);
      rdchk(MSI_IRQSTAT_OFS, 32'h1);
      $display("test card detect done");
      pulse(0);
      chk(32'(n), 32'(PL));
      apb(1'b1, MSI_CTRL_OFS, 32'h11);
      cnt(0);
      chk(32'(n), 32'(PL));
      rdchk(MSI_IRQSTAT_OFS, 32'h8);
      $display("test ring done");
      pulse(2);
      chk({31'h0, hostWake}, 32'h1);
      apb(1'b1, MSI_CTRL_OFS, 32'h1);
      @(negedge clk);
      chk({31'h0, hostWake}, 32'h0);
      apb(1'b1, MSI_CTRL_OFS, 32'h5);
      pulse(0);
      chk({31'h0, hostWake}, 32'h1);
      rdchk(MSI_IRQSTAT_OFS, 32'h8);
      @(negedge clk);
      chk({31'h0, hostWake}, 32'h0);
      $display("test wake done");
      apb(1'b1, MSI_CTRL_OFS, 32'h3);
      repeat (2) @(negedge clk);
      chk({ledOe, ledSink, ledLit}, 32'h5);
      $display("test led done");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         fixValid   <= (i == 0);
         uncertHigh <= (i == 2);
         pulse(1);
         chk(32'(n), (i == 2) ? 32'h0 : 32'(PL));
      end
      $display("test second pulse done");
      finishTest();
   end
endmodule
